// *** rtl/pcd_pkg.sv ***
// Package: constants, types and register map of the clock mode divider
package pcd_pkg;

  // ==========================================================
  // Register map (byte addresses, one word each)
  localparam logic [3:0] PCD_CTRL_OFS = 4'h0;
  localparam logic [3:0] PCD_STATUS_OFS = 4'h4;

  // ==========================================================
  // Control field positions and reset values
  localparam int PCD_CTRL_DIV_LSB = 0;
  localparam int PCD_CTRL_LEGACY_BIT = 2;
  localparam logic [1:0] PCD_DIV_RESET = 2'h0;
  localparam logic PCD_LEGACY_RESET = 1'b0;

  // ==========================================================
  // Status field positions
  localparam int PCD_ST_LOCKED_BIT = 0;
  localparam int PCD_ST_PRESENT_BIT = 1;
  localparam int PCD_ST_PINS_LSB = 2;
  localparam int PCD_ST_DIV_LSB = 4;
  localparam int PCD_ST_LEGACY_BIT = 6;
  localparam int PCD_ST_STOPPED_BIT = 7;

  // ==========================================================
  // Counts
  localparam logic [7:0] PCD_LOCK_LAST = 8'hff;
  localparam logic [15:0] PCD_NOCLK_LIMIT = 16'hffff;
  localparam logic [4:0] PCD_PLL_MULT2 = 5'h0a;
  localparam logic [4:0] PCD_REDUCED_TICKS = 5'h10;
  localparam logic [4:0] PCD_FULL_TICKS = 5'h01;

  // ==========================================================
  // Clock mode pin patterns {select_a, select_b}
  localparam logic [1:0] PCD_PINS_STATIC = 2'h0;
  localparam logic [1:0] PCD_PINS_HALF = 2'h1;
  localparam logic [1:0] PCD_PINS_UNITY = 2'h2;
  localparam logic [1:0] PCD_PINS_PLL = 2'h3;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    PCD_DIV_FULL = 2'b00,
    PCD_DIV_REDUCED = 2'b01,
    PCD_DIV_STOP = 2'b11
  } pcd_div_type;

  typedef enum logic [1:0] {
    PCD_PLL_OFF = 2'b00,
    PCD_PLL_ACQUIRE = 2'b01,
    PCD_PLL_LOCKED = 2'b11
  } pcd_pll_type;

  typedef struct packed {
    logic legacy;
    pcd_div_type divMode;
  } pcd_ctrl_type;

endpackage

// *** rtl/pcd_clock_ctrl.sv ***
// Clock mode decode, reference combine, multiplier model and divider
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Pin synchroniser: three stages, change accepted when two agree
module pcd_pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstSync_n,
  // Data
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= pinIn;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // Filtered value only follows once stages two and three agree
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      pinOut <= '0;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (s2[i] == s3[i]) begin
          pinOut[i] <= s3[i];
        end
      end
    end
  end
endmodule

// ==========================================================
// Top
module pcd_clock_ctrl
  import pcd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Clock pins
  input wire logic clock_mode_select_a,
  input wire logic clock_mode_select_b,
  input wire logic external_reference_clock,
  input wire logic crystal_input,
  output logic crystal_drive_output,
  output logic pll_power_on,
  // Device reset and interrupt pins
  input wire logic deviceReset_n,
  input wire logic [3:0] interruptPin_n,
  // Phase clocks
  output logic output_phase_clock_a,
  output logic output_phase_clock_b
);

  // ==========================================================
  // Reset release
  logic rstMeta;
  logic rstSync_n;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync_n <= rstMeta;
    end
  end

  // ==========================================================
  // Pin inputs
  logic [8:0] pinsRaw;
  logic [8:0] pinsF;
  logic [1:0] modePins;
  logic refClk;
  logic xtalF;
  logic devRst_n;
  logic [3:0] intF_n;

  assign pinsRaw = {interruptPin_n, deviceReset_n, crystal_input,
                    external_reference_clock, clock_mode_select_a,
                    clock_mode_select_b};

  pcd_pin_sync #(.WIDTH(9)) pinSync (
    .clk(mclk),
    .rstSync_n(rstSync_n),
    .pinIn(pinsRaw),
    .pinOut(pinsF)
  );

  assign modePins = {pinsF[1], pinsF[0]};
  assign xtalF = pinsF[3];
  assign refClk = pinsF[2] ^ pinsF[3];
  assign devRst_n = pinsF[4];
  assign intF_n = pinsF[8:5];

  // ==========================================================
  // Edge detection on the combined reference and device reset
  logic refLast;
  logic devRstLast;
  logic refRise;
  logic refFall;
  logic resetFall;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      refLast <= 1'b0;
      // Filtered pin reads low after reset, so no false fall follows
      devRstLast <= 1'b0;
    end else begin
      refLast <= refClk;
      devRstLast <= devRst_n;
    end
  end

  assign refRise = refClk & ~refLast;
  assign refFall = ~refClk & refLast;
  assign resetFall = devRstLast & ~devRst_n;

  // ==========================================================
  // Oscillator feedback and PLL power
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      crystal_drive_output <= 1'b0;
      pll_power_on <= 1'b0;
    end else begin
      crystal_drive_output <= (modePins != PCD_PINS_STATIC) & ~xtalF;
      pll_power_on <= (modePins == PCD_PINS_PLL);
    end
  end

  // ==========================================================
  // Reference period tracking; saturation means no input clock
  logic [15:0] periodCnt;
  logic [15:0] period;
  logic refPresent;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      periodCnt <= '0;
      period <= PCD_NOCLK_LIMIT;
    end else if (refRise) begin
      periodCnt <= '0;
      period <= periodCnt + 16'h0001;
    end else if (periodCnt != PCD_NOCLK_LIMIT) begin
      periodCnt <= periodCnt + 16'h0001;
    end
  end

  assign refPresent = (periodCnt != PCD_NOCLK_LIMIT);

  // ==========================================================
  // Multiplier model: ten half-period ticks per reference period
  logic [16:0] phaseAcc;
  logic [16:0] next_phaseAcc;
  logic pllTick;

  always_comb begin
    next_phaseAcc = phaseAcc + {12'h000, PCD_PLL_MULT2};
    pllTick = 1'b0;
    if (next_phaseAcc >= {1'b0, period}) begin
      next_phaseAcc = next_phaseAcc - {1'b0, period};
      pllTick = 1'b1;
    end
  end

  // Reference rising edges realign the accumulator so the output tracks
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      phaseAcc <= '0;
    end else if (refRise || modePins != PCD_PINS_PLL) begin
      phaseAcc <= '0;
    end else begin
      phaseAcc <= next_phaseAcc;
    end
  end

  // ==========================================================
  // Lock counter and PLL state; lock stays until the reference is lost in PLL mode
  logic [7:0] lockCnt;
  pcd_pll_type pllState;

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      lockCnt <= '0;
      pllState <= PCD_PLL_OFF;
    end else if (modePins != PCD_PINS_PLL) begin
      // PCD_PLL_LOCKED state is kept once gained, so later starts skip acquire
      if (pllState != PCD_PLL_LOCKED) begin
        pllState <= PCD_PLL_OFF;
      end
    end else begin
      unique case (pllState)
        PCD_PLL_OFF: begin
          pllState <= PCD_PLL_ACQUIRE;
        end
        PCD_PLL_ACQUIRE: begin
          if (refRise && devRst_n && refPresent) begin
            if (lockCnt == PCD_LOCK_LAST) begin
              pllState <= PCD_PLL_LOCKED;
            end
            lockCnt <= lockCnt + 8'h01;
          end
        end
        PCD_PLL_LOCKED: begin
          if (!refPresent) begin
            pllState <= PCD_PLL_ACQUIRE;
          end
        end
        default: begin
          pllState <= PCD_PLL_OFF;
        end
      endcase
    end
  end

  // ==========================================================
  // Control register
  pcd_ctrl_type ctrl;
  logic ack;
  logic wrHit;

  assign wrHit = write & ack & (address == PCD_CTRL_OFS) & byteenable[0];

  // Wake-up wins over a software write in the same cycle
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ctrl.divMode <= pcd_div_type'(PCD_DIV_RESET);
      ctrl.legacy <= PCD_LEGACY_RESET;
    end else if (ctrl.divMode == PCD_DIV_STOP &&
                 (!devRst_n || intF_n != 4'hf)) begin
      ctrl.divMode <= PCD_DIV_FULL;
    end else if (resetFall) begin
      ctrl.divMode <= PCD_DIV_FULL;
    end else if (wrHit) begin
      ctrl.legacy <= writedata[PCD_CTRL_LEGACY_BIT];
      unique case (writedata[PCD_CTRL_DIV_LSB +: 2])
        2'b01: ctrl.divMode <= PCD_DIV_REDUCED;
        2'b11: ctrl.divMode <= PCD_DIV_STOP;
        default: ctrl.divMode <= PCD_DIV_FULL;
      endcase
    end
  end

  // ==========================================================
  // Source tick selection per mode pins
  logic pllSel;
  logic srcTick;

  always_comb begin
    unique case (modePins)
      PCD_PINS_HALF: srcTick = refRise;
      PCD_PINS_PLL: srcTick = pllSel ? pllTick : refRise;
      default: srcTick = refRise | refFall;
    endcase
  end

  // ==========================================================
  // Divider; settings are taken only at a low-phase boundary
  logic coreClk;
  logic [5:0] tickCnt;
  logic [5:0] divTicks;
  pcd_ctrl_type active;
  logic boundary;

  assign boundary = ~coreClk & (tickCnt == 6'h00);

  // One spare bit so reduced rate in legacy mode still counts 32 ticks
  always_comb begin
    divTicks = (active.divMode == PCD_DIV_REDUCED) ?
               {1'b0, PCD_REDUCED_TICKS} : {1'b0, PCD_FULL_TICKS};
    if (active.legacy) begin
      divTicks = {divTicks[4:0], 1'b0};
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      active <= '0;
      pllSel <= 1'b0;
    end else if (boundary) begin
      active <= ctrl;
      pllSel <= (pllState == PCD_PLL_LOCKED);
    end
  end

  // Reset falling restarts the count against the present phase
  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      tickCnt <= '0;
      coreClk <= 1'b0;
    end else if (resetFall) begin
      tickCnt <= '0;
    end else if (boundary && active.divMode == PCD_DIV_STOP) begin
      tickCnt <= '0;
    end else if (srcTick) begin
      if (tickCnt == divTicks - 6'h01) begin
        tickCnt <= '0;
        coreClk <= ~coreClk;
      end else begin
        tickCnt <= tickCnt + 6'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      output_phase_clock_a <= 1'b0;
      output_phase_clock_b <= 1'b1;
    end else begin
      output_phase_clock_a <= coreClk;
      output_phase_clock_b <= ~coreClk;
    end
  end

  // ==========================================================
  // Bus slave: one wait state on every access
  logic [31:0] next_readdata;

  assign waitrequest = (read | write) & ~ack;

  always_comb begin
    next_readdata = '0;
    unique case (address)
      PCD_CTRL_OFS: begin
        next_readdata[PCD_CTRL_DIV_LSB +: 2] = ctrl.divMode;
        next_readdata[PCD_CTRL_LEGACY_BIT] = ctrl.legacy;
      end
      PCD_STATUS_OFS: begin
        next_readdata[PCD_ST_LOCKED_BIT] = (pllState == PCD_PLL_LOCKED);
        next_readdata[PCD_ST_PRESENT_BIT] = refPresent;
        next_readdata[PCD_ST_PINS_LSB +: 2] = modePins;
        next_readdata[PCD_ST_DIV_LSB +: 2] = active.divMode;
        next_readdata[PCD_ST_LEGACY_BIT] = active.legacy;
        next_readdata[PCD_ST_STOPPED_BIT] =
          (active.divMode == PCD_DIV_STOP) & boundary;
      end
      default: next_readdata = '0;
    endcase
  end

  always_ff @(posedge mclk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      ack <= 1'b0;
      readdata <= '0;
    end else begin
      ack <= (read | write) & ~ack;
      if (read && !ack) begin
        readdata <= next_readdata;
      end
    end
  end

endmodule

`default_nettype wire

// *** tb/pcd_ref_source.sv ***
// Reference clock source model for the clock pins
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Source
module pcd_ref_source #(
  parameter int HALF = 15
) (
  // Clock
  input wire logic mclk,
  // Reference pins
  output logic refClk,
  output logic crystal
);
  int cnt = 0;
  initial refClk = 1'b0;
  // Runs from time zero so a clock is present before reset is released
  always @(posedge mclk) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) begin
      refClk <= !refClk;
    end
  end
  // Unused source grounded so the combine passes the live one
  assign crystal = 1'b0;
endmodule
`default_nettype wire

// *** tb/pcd_clock_ctrl_assertions.sv ***
// Assertions on the clock mode divider ports
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Checker
module pcd_clock_ctrl_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bus
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Pins
  input wire logic clock_mode_select_a,
  input wire logic clock_mode_select_b,
  input wire logic crystal_input,
  input wire logic crystal_drive_output,
  input wire logic pll_power_on,
  input wire logic [3:0] interruptPin_n,
  input wire logic output_phase_clock_a,
  input wire logic output_phase_clock_b
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic [1:0] pins = {clock_mode_select_a, clock_mode_select_b};
  wire logic req = read | write;
  wire logic byp = (pins inside {2'h1, 2'h2}) && !crystal_input;
  // Pins pass a synchroniser, so each mode must stand a while first
  sequence pllSteady;
    (pins == 2'h3)[*8] ##1 (pins == 2'h3)[*8];
  endsequence
  sequence bypSteady;
    byp[*8] ##1 byp[*8];
  endsequence
  sequence staticSteady;
    (pins == 2'h0)[*8] ##1 (pins == 2'h0)[*8];
  endsequence
  sequence wakeHeld;
    (interruptPin_n != 4'hf)[*8] ##1 (interruptPin_n != 4'hf)[*8];
  endsequence
  pll_power_a: assert property (pllSteady |-> pll_power_on)
    else $error("pll power off in x5 mode");
  bypass_power_a: assert property (bypSteady |->
    !pll_power_on && crystal_drive_output)
    else $error("bypass mode power or feedback wrong");
  static_mode_a: assert property (staticSteady |->
    !pll_power_on && !crystal_drive_output)
    else $error("static mode not quiet");
  phase_pair_a: assert property (
    output_phase_clock_b == !output_phase_clock_a)
    else $error("phase clocks overlap");
  runt_free_a: assert property (
    $rose(output_phase_clock_a) |=> output_phase_clock_a)
    else $error("runt pulse on phase clock");
  wake_int_a: assert property (
    wakeHeld |-> ##[1:300] $changed(output_phase_clock_a))
    else $error("no clock while interrupt pin low");
  wait_first_a: assert property (req && !$past(req) |-> waitrequest)
    else $error("no wait state on first cycle");
  wait_one_a: assert property (req && waitrequest |=> !waitrequest)
    else $error("more than one wait state");
endmodule
bind pcd_clock_ctrl pcd_clock_ctrl_assertions i_chk (.mclk(mclk),
  .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
  .clock_mode_select_a(clock_mode_select_a),
  .clock_mode_select_b(clock_mode_select_b),
  .crystal_input(crystal_input), .crystal_drive_output(crystal_drive_output),
  .pll_power_on(pll_power_on), .interruptPin_n(interruptPin_n),
  .output_phase_clock_a(output_phase_clock_a),
  .output_phase_clock_b(output_phase_clock_b));
`default_nettype wire

// *** tb/pcd_clock_ctrl_tb.sv ***
// Testbench of the clock mode divider
`timescale 1ns/1ps
`default_nettype none
module pcd_clock_ctrl_tb
  import pcd_pkg::*;
;
  logic mclk, rst_n, read, write, waitrequest, selA, selB, refClk, xtal;
  logic drive, pwr, devRst_n, phA, phB, refD, phD;
  logic [3:0] address, intN;
  logic [31:0] wdata, rdata, refRises, phRises, comparisons, miscompares;
  logic [31:0] p, d;
  int i;
  // Rows: pins, control, phase rises per 64 reference rises
  localparam logic [13:0] ROWS [8] = '{{2'h0, 3'h0, 9'h040},
    {2'h2, 3'h0, 9'h040}, {2'h1, 3'h0, 9'h020}, {2'h3, 3'h0, 9'h140},
    {2'h2, 3'h1, 9'h004}, {2'h2, 3'h4, 9'h020}, {2'h3, 3'h1, 9'h014},
    {2'h1, 3'h4, 9'h010}};
  pcd_ref_source i_src (.mclk(mclk), .refClk(refClk), .crystal(xtal));
  pcd_clock_ctrl i_dut (.mclk(mclk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .byteenable(4'hf), .writedata(wdata),
    .readdata(rdata), .waitrequest(waitrequest),
    .clock_mode_select_a(selA), .clock_mode_select_b(selB),
    .external_reference_clock(refClk), .crystal_input(xtal),
    .crystal_drive_output(drive), .pll_power_on(pwr),
    .deviceReset_n(devRst_n), .interruptPin_n(intN),
    .output_phase_clock_a(phA), .output_phase_clock_b(phB));
  // ==========================================================
  // Helpers
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    refD <= refClk;
    phD <= phA;
    if (refClk && !refD) refRises <= refRises + 1;
    if (phA && !phD) phRises <= phRises + 1;
  end
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
      miscompares = miscompares + 1;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Edge counts may slip by one at the window ends
  function automatic logic [31:0] tol(input logic [31:0] s, e);
    return (s + 1 >= e && s <= e + 1) ? e : s;
  endfunction
  task automatic bus(input logic wr, input logic [3:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    address <= a;
    wdata <= wd;
    read <= !wr;
    write <= wr;
    do @(posedge mclk); while (waitrequest !== 1'b0);
    rd = rdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic waitRef(input logic [31:0] n);
    logic [31:0] r0;
    r0 = refRises;
    while (refRises - r0 < n) @(posedge mclk);
  endtask
  task automatic meas(output logic [31:0] pc);
    logic [31:0] p0;
    p0 = phRises;
    waitRef(32'h40);
    pc = phRises - p0;
  endtask
  task automatic results;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    repeat (100000) @(posedge mclk);
    miscompares = miscompares + 1;
    results();
  end
  initial begin
    {rst_n, read, write, refD, phD, selA, selB, devRst_n} = 8'h1f;
    {address, intN, wdata, refRises, phRises} = {8'h0f, 96'h0};
    {comparisons, miscompares} = 64'h0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (4) @(posedge mclk);
    bus(1'b0, PCD_CTRL_OFS, 32'h0, d);
    chk("ctrl reset", d, 32'h0);
    meas(p);
    chk("acquire rate", tol(p, 32'h20), 32'h20);
    $display("reset test done");
    while (refRises < 32'h140) @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      {selA, selB} <= ROWS[i][13:12];
      bus(1'b1, PCD_CTRL_OFS, {29'h0, ROWS[i][11:9]}, d);
      waitRef(32'h20);
      meas(p);
      d = {23'h0, ROWS[i][8:0]};
      chk("rate", tol(p, d), d);
      $display("row %0d done", i);
    end
    {selA, selB} <= 2'h2;
    bus(1'b1, PCD_CTRL_OFS, 32'h3, d);
    waitRef(32'h10);
    meas(p);
    chk("stop rate", p, 32'h0);
    chk("parked", {31'h0, phA}, 32'h0);
    bus(1'b0, PCD_STATUS_OFS, 32'h0, d);
    chk("stopped", {31'h0, d[PCD_ST_STOPPED_BIT]}, 32'h1);
    chk("active div", {30'h0, d[5:4]}, 32'h3);
    intN <= 4'hb;
    waitRef(32'h8);
    bus(1'b0, PCD_CTRL_OFS, 32'h0, d);
    chk("wake div", d, 32'h0);
    meas(p);
    chk("wake rate", tol(p, 32'h40), 32'h40);
    intN <= 4'hf;
    $display("interrupt wake test done");
    bus(1'b1, PCD_CTRL_OFS, 32'h3, d);
    waitRef(32'h10);
    devRst_n <= 1'b0;
    waitRef(32'h8);
    bus(1'b0, PCD_CTRL_OFS, 32'h0, d);
    chk("reset wake div", d, 32'h0);
    meas(p);
    chk("reset wake rate", tol(p, 32'h40), 32'h40);
    devRst_n <= 1'b1;
    $display("reset wake test done");
    bus(1'b0, PCD_STATUS_OFS, 32'h0, d);
    chk("locked", {31'h0, d[PCD_ST_LOCKED_BIT]}, 32'h1);
    chk("pins", {30'h0, d[3:2]}, 32'h2);
    chk("present", {31'h0, d[PCD_ST_PRESENT_BIT]}, 32'h1);
    bus(1'b0, 4'h8, 32'h0, d);
    chk("unmapped", d, 32'h0);
    $display("status test done");
    results();
  end
endmodule
`default_nettype wire
